// ### shared/dbg_link_map.svh
// Command codes, field lengths, register layout and bit timing of the debug link
`ifndef DBG_LINK_MAP_SVH
`define DBG_LINK_MAP_SVH

// Command codes
`define CMD_BACKGROUND    8'h90
`define CMD_GO            8'h08
`define CMD_READ_STATUS   8'he4
`define CMD_WRITE_CONTROL 8'hc4
`define CMD_READ_BYTE     8'he0
`define CMD_WRITE_BYTE    8'hc0
`define CMD_READ_WORD     8'he8
`define CMD_WRITE_WORD    8'hc8
`define CMD_READ_BKPT     8'he2
`define CMD_WRITE_BKPT    8'hc2

// Field lengths in bits
`define CODE_BITS 5'h08
`define ADDR_BITS 5'h10
`define BYTE_BITS 5'h08
`define WORD_BITS 5'h10

// Bit timing in debug clock cycles
`define WAIT_GAP      8'h10
`define RX_SAMPLE     8'h08
`define TX_ZERO_LOW   8'h0d
`define HOST_SAMPLE   8'h0a
`define HOST_ONE_LOW  8'h04
`define HOST_ZERO_LOW 8'h0d
`define BIT_PERIOD    8'h18
`define SYNC_DETECT   8'h40
`define SYNC_REQ_LOW  8'h50
`define SYNC_DELAY    8'h10
`define SYNC_PULSE    8'h80
`define SYNC_TIMEOUT  16'h03e8

// Debug status/control layout and reset values
`define STAT_BKPT_EN 7
`define CTRL_RESET   8'h00
`define BKPT_RESET   16'h0000

`endif

// ### shared/dbg_link_pkg.sv
// Types and command decoding shared by both ends of the debug link
`include "dbg_link_map.svh"
package dbg_link_pkg;

	typedef enum logic [2:0] {
		K_NONE   = 3'b000,
		K_BG     = 3'b001,
		K_GO     = 3'b010,
		K_STATUS = 3'b011,
		K_CTRL   = 3'b100,
		K_MEM    = 3'b101,
		K_BKPT   = 3'b110
	} cmd_kind_t;

	typedef enum logic [2:0] {
		PH_CODE = 3'b000,
		PH_ADDR = 3'b001,
		PH_WIN  = 3'b010,
		PH_WAIT = 3'b011,
		PH_OUT  = 3'b100,
		PH_SYNC = 3'b101
	} phase_t;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_FRAME = 2'b01,
		H_SYNC  = 2'b10,
		H_PUSH  = 2'b11
	} host_state_t;

	typedef struct packed {
		logic      known;
		logic      halt_only;
		logic      has_addr;
		logic [4:0] wlen;
		logic      has_wait;
		logic [4:0] rlen;
		cmd_kind_t kind;
	} cmd_info_t;

	// Frame layout of each command: code / address / write data / gap / read data
	function automatic cmd_info_t decode_cmd(input logic [7:0] code);
		cmd_info_t i;
		i = '{1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 5'h00, K_NONE};
		case (code)
		`CMD_BACKGROUND:    i = '{1'b1, 1'b0, 1'b0, 5'h00, 1'b0, 5'h00, K_BG};
		`CMD_GO:            i = '{1'b1, 1'b1, 1'b0, 5'h00, 1'b0, 5'h00, K_GO};
		`CMD_READ_STATUS:   i = '{1'b1, 1'b0, 1'b0, 5'h00, 1'b0, `BYTE_BITS, K_STATUS};
		`CMD_WRITE_CONTROL: i = '{1'b1, 1'b0, 1'b0, `BYTE_BITS, 1'b0, 5'h00, K_CTRL};
		`CMD_READ_BYTE:     i = '{1'b1, 1'b0, 1'b1, 5'h00, 1'b1, `BYTE_BITS, K_MEM};
		`CMD_WRITE_BYTE:    i = '{1'b1, 1'b0, 1'b1, `BYTE_BITS, 1'b1, 5'h00, K_MEM};
		`CMD_READ_WORD:     i = '{1'b1, 1'b1, 1'b1, 5'h00, 1'b1, `WORD_BITS, K_MEM};
		`CMD_WRITE_WORD:    i = '{1'b1, 1'b1, 1'b1, `WORD_BITS, 1'b1, 5'h00, K_MEM};
		`CMD_READ_BKPT:     i = '{1'b1, 1'b1, 1'b0, 5'h00, 1'b0, `WORD_BITS, K_BKPT};
		`CMD_WRITE_BKPT:    i = '{1'b1, 1'b1, 1'b0, `WORD_BITS, 1'b0, 5'h00, K_BKPT};
		default:            i = '{1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 5'h00, K_NONE};
		endcase
		return i;
	endfunction

	// Phase that follows cur; PH_CODE means the frame is over
	function automatic phase_t next_phase(input phase_t cur, input cmd_info_t i);
		phase_t n;
		n = PH_CODE;
		if (i.rlen != 5'h00 && cur < PH_OUT)
			n = PH_OUT;
		if (i.has_wait && cur < PH_WAIT)
			n = PH_WAIT;
		if (i.wlen != 5'h00 && cur < PH_WIN)
			n = PH_WIN;
		if (i.has_addr && cur < PH_ADDR)
			n = PH_ADDR;
		return n;
	endfunction

	// Number of bits carried by a phase
	function automatic logic [4:0] field_len(input phase_t p, input cmd_info_t i);
		logic [4:0] n;
		n = 5'h00;
		case (p)
		PH_CODE: n = `CODE_BITS;
		PH_ADDR: n = `ADDR_BITS;
		PH_WIN:  n = i.wlen;
		PH_OUT:  n = i.rlen;
		default: n = 5'h00;
		endcase
		return n;
	endfunction

endpackage

// ### shared/dbg_link_if.sv
// Shared debug pin: each end's drive and the resolved line level
`timescale 1ns/10ps
`default_nettype none
interface dbg_link_if;
	logic host_out; // Host pin value
	logic host_oe;  // Host drives the pin
	logic tgt_out;  // Target pin value
	logic tgt_oe;   // Target drives the pin
	logic level;    // Resolved pin level

	// Low drive wins; an undriven line rests high on the pull-up
	assign level = ~((host_oe & ~host_out) | (tgt_oe & ~tgt_out));

	modport target (input level, output tgt_out, output tgt_oe);
	modport host (input level, output host_out, output host_oe);
endinterface
`default_nettype wire

// ### design/dbg_rsp_buffer.sv
// Small valid/ready FIFO holding answers returned by the debug target
`timescale 1ns/10ps
`default_nettype none
module dbg_rsp_buffer #(
	parameter int WIDTH = 16, // Word width
	parameter int DEPTH = 2   // Number of entries
) (
	input  wire logic             clk,       // Debug clock
	input  wire logic             srst,      // Synchronous reset
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word in
	output logic                  out_valid, // Word available
	input  wire logic             out_ready, // Consumer takes word
	output logic [WIDTH-1:0]      out_data   // Oldest word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != FULL);
	assign out_valid = (count != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rp];

	// Storage; written only on an accepted push
	always_ff @(posedge clk) begin
		if (push)
			mem[wp] <= in_data;
	end

	// Pointers and fill level; simultaneous push and pop keep the level
	always_ff @(posedge clk) begin
		if (srst) begin
			wp    <= '0;
			rp    <= '0;
			count <= '0;
		end else begin
			if (push)
				wp <= (wp == LAST) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == LAST) ? '0 : rp + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### design/dbg_target.sv
// Target end of the single-wire debug link: pin timing and command execution
`timescale 1ns/10ps
`default_nettype none
`include "dbg_link_map.svh"
module dbg_target (
	input  wire logic        clk,       // Debug clock
	input  wire logic        srst,      // Synchronous reset, active high
	dbg_link_if.target       link,      // Debug pin
	output logic             mem_req,   // Memory access request, held until mem_ack
	output logic             mem_we,    // Access is a write
	output logic             mem_word,  // Access is 16 bits wide
	output logic [15:0]      mem_addr,  // Access address
	output logic [15:0]      mem_wdata, // Write data, byte in low bits
	input  wire logic [15:0] mem_rdata, // Read data, byte in low bits
	input  wire logic        mem_ack,   // Access done
	output logic             halted,    // In active background mode
	output logic             bkpt_en,   // Breakpoint enable from control
	output logic [15:0]      bkpt_addr  // Breakpoint register
);
	import dbg_link_pkg::*;

	logic        s1;
	logic        s2;
	logic        s3;
	logic        fall;
	logic        rise;
	logic        busy;
	logic [7:0]  cnt;
	logic [7:0]  low_cnt;
	logic [4:0]  bits;
	logic [15:0] sh;
	logic [15:0] rx_word;
	logic [15:0] out_word;
	logic [7:0]  ctrl;
	logic [7:0]  status;
	logic        last;
	logic        rx_take;
	logic        tx_end;
	logic        wait_done;
	logic        need_mem;
	logic        step;
	logic        sync_hit;
	logic        exec;
	logic        exec_next;
	phase_t      phase;
	phase_t      np;
	cmd_info_t   info;
	cmd_info_t   info_next;

	// Pin synchroniser; the host edge is asynchronous to this clock
	always_ff @(posedge clk) begin
		s1 <= link.level;
		s2 <= s1;
		s3 <= s2;
	end

	// Edges are seen where the second and third stages differ
	assign fall = ~s2 & s3;
	assign rise = s2 & ~s3;

	// Bit and field events
	assign rx_word   = {sh[14:0], s3};
	assign last      = (bits == 5'h01);
	assign rx_take   = busy & (cnt == `RX_SAMPLE) & (phase inside {PH_CODE, PH_ADDR, PH_WIN});
	assign tx_end    = busy & (cnt == `TX_ZERO_LOW + 8'h01) & (phase == PH_OUT);
	assign need_mem  = exec & (info.kind == K_MEM);
	assign mem_req   = (phase == PH_WAIT) & need_mem;
	assign wait_done = (phase == PH_WAIT) & (~need_mem | mem_ack);
	assign step      = ((rx_take | tx_end) & last) | wait_done;
	assign sync_hit  = (low_cnt == `SYNC_DETECT);

	// Decode at the end of the code field; later phases use the stored copy
	assign info_next = (phase == PH_CODE) ? decode_cmd(rx_word[7:0]) : info;
	assign exec_next = (phase == PH_CODE)
		? (info_next.known & (~info_next.halt_only | halted)) : exec;
	assign np        = next_phase(phase, info_next);
	assign status    = {ctrl[7], halted, ctrl[5:0]};
	assign bkpt_en   = ctrl[`STAT_BKPT_EN];

	// Word returned to the host; refused reads give ones so the pin stays released
	always_comb begin
		out_word = 16'hffff;
		if (exec_next) begin
			case (info_next.kind)
			K_STATUS: out_word = {status, 8'h00};
			K_BKPT:   out_word = bkpt_addr;
			K_MEM:    out_word = (info_next.rlen == `WORD_BITS) ? mem_rdata
				: {mem_rdata[7:0], 8'h00};
			default:  out_word = 16'hffff;
			endcase
		end
	end

	// Long low from the host is a timing probe; own drive is not counted
	always_ff @(posedge clk) begin
		if (srst)
			low_cnt <= 8'h00;
		else if (s3 | link.tgt_oe | (phase == PH_SYNC))
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end

	// Phase sequencer and bit engine
	always_ff @(posedge clk) begin
		if (srst) begin
			phase <= PH_CODE;
			busy  <= 1'b0;
			cnt   <= 8'h00;
			bits  <= `CODE_BITS;
			sh    <= 16'h0000;
		end else if (sync_hit) begin
			phase <= PH_SYNC;
			busy  <= 1'b0;
			cnt   <= 8'h00;
		end else if (phase == PH_SYNC) begin
			// Wait for the host to release, then delay and answer
			if (!busy) begin
				busy <= rise;
				cnt  <= 8'h00;
			end else if (cnt == `SYNC_DELAY + `SYNC_PULSE) begin
				phase <= PH_CODE;
				busy  <= 1'b0;
				bits  <= `CODE_BITS;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end else if (step) begin
			phase <= np;
			busy  <= 1'b0;
			bits  <= field_len(np, info_next);
			sh    <= (np == PH_OUT) ? out_word : rx_word;
		end else if (rx_take) begin
			sh   <= rx_word;
			bits <= bits - 5'h01;
			busy <= 1'b0;
		end else if (tx_end) begin
			sh   <= {sh[14:0], 1'b1};
			bits <= bits - 5'h01;
			busy <= 1'b0;
		end else if (busy) begin
			cnt <= cnt + 8'h01;
		end else if (fall && phase != PH_WAIT) begin
			busy <= 1'b1; // Bit time opened by the host
			cnt  <= 8'h00;
		end
	end

	// Command decode result, kept for the rest of the frame
	always_ff @(posedge clk) begin
		if (srst) begin
			info     <= decode_cmd(8'h00);
			exec     <= 1'b0;
			mem_we   <= 1'b0;
			mem_word <= 1'b0;
		end else if (step && phase == PH_CODE) begin
			info     <= info_next;
			exec     <= exec_next;
			mem_we   <= (info_next.wlen != 5'h00);
			mem_word <= (info_next.wlen == `WORD_BITS) | (info_next.rlen == `WORD_BITS);
		end
	end

	// Start mode strap and halt/resume commands
	always_ff @(posedge clk) begin
		// Both agreeing stages are used so an unsettled first flop cannot leak into the strap
		if (srst)
			halted <= ~(s2 | s3); // Low pin during reset starts halted
		else if (step && phase == PH_CODE && exec_next && info_next.kind == K_BG)
			halted <= 1'b1;
		else if (step && phase == PH_CODE && exec_next && info_next.kind == K_GO)
			halted <= 1'b0;
	end

	// Address and write data captured at the end of their fields
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_addr  <= 16'h0000;
			mem_wdata <= 16'h0000;
			ctrl      <= `CTRL_RESET;
			bkpt_addr <= `BKPT_RESET;
		end else if (step && exec) begin
			if (phase == PH_ADDR)
				mem_addr <= rx_word;
			// A byte field leaves address bits in the shifter's top half; clear them
			if (phase == PH_WIN && info.kind == K_MEM)
				mem_wdata <= (info.wlen == `WORD_BITS) ? rx_word
					: {8'h00, rx_word[7:0]};
			if (phase == PH_WIN && info.kind == K_CTRL)
				ctrl <= rx_word[7:0];
			if (phase == PH_WIN && info.kind == K_BKPT)
				bkpt_addr <= rx_word;
		end
	end

	// Pin drive: low phases followed by one cycle of active high speed-up
	always_ff @(posedge clk) begin
		if (srst) begin
			link.tgt_oe  <= 1'b0;
			link.tgt_out <= 1'b1;
		end else if (phase == PH_SYNC && busy && cnt >= `SYNC_DELAY
			&& cnt < `SYNC_DELAY + `SYNC_PULSE) begin
			link.tgt_oe  <= 1'b1; // Timed probe answer
			link.tgt_out <= 1'b0;
		end else if (phase == PH_SYNC && busy && cnt == `SYNC_DELAY + `SYNC_PULSE) begin
			link.tgt_oe  <= 1'b1;
			link.tgt_out <= 1'b1;
		end else if (phase == PH_OUT && busy && !sh[15] && cnt < `TX_ZERO_LOW) begin
			link.tgt_oe  <= 1'b1;
			link.tgt_out <= 1'b0;
		end else if (phase == PH_OUT && busy && !sh[15] && cnt == `TX_ZERO_LOW) begin
			link.tgt_oe  <= 1'b1; // Speed-up pulse
			link.tgt_out <= 1'b1;
		end else begin
			link.tgt_oe  <= 1'b0; // Ones and idle leave the line to the pull-up
			link.tgt_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### design/dbg_host.sv
// Host end of the single-wire debug link: frames commands and collects answers
`timescale 1ns/10ps
`default_nettype none
`include "dbg_link_map.svh"
module dbg_host (
	input  wire logic        clk,       // Clock at the target debug rate
	input  wire logic        srst,      // Synchronous reset, active high
	dbg_link_if.host         link,      // Debug pin
	input  wire logic        cmd_valid, // Command offered
	output logic             cmd_ready, // Command taken this cycle
	input  wire logic [7:0]  cmd_code,  // Command code
	input  wire logic [15:0] cmd_addr,  // Address field
	input  wire logic [15:0] cmd_wdata, // Write data, byte in low bits
	input  wire logic        sync_req,  // Run a timing probe
	output logic             rsp_valid, // Answer available
	input  wire logic        rsp_ready, // Answer consumed
	output logic [15:0]      rsp_data   // Read data or probe pulse length
);
	import dbg_link_pkg::*;

	logic        s1;
	logic        s2;
	logic        s3;
	logic [15:0] cnt;
	logic [15:0] sh;
	logic [15:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] push_q;
	logic [4:0]  bits;
	logic [1:0]  sstage;
	logic [7:0]  low_len;
	logic        bit_end;
	logic        gap_end;
	logic        fstep;
	logic        push_valid;
	logic        push_ready;
	host_state_t hst;
	phase_t      phase;
	phase_t      np;
	cmd_info_t   info;

	// Pin synchroniser
	always_ff @(posedge clk) begin
		s1 <= link.level;
		s2 <= s1;
		s3 <= s2;
	end

	// Bit and field events; a stall in the answer buffer holds the host in H_PUSH
	assign cmd_ready  = (hst == H_IDLE) & ~sync_req;
	assign push_valid = (hst == H_PUSH);
	assign low_len    = (phase == PH_OUT || sh[15]) ? `HOST_ONE_LOW : `HOST_ZERO_LOW;
	assign bit_end    = (hst == H_FRAME) & (phase != PH_WAIT)
		& (cnt == {8'h00, `BIT_PERIOD - 8'h01});
	assign gap_end    = (hst == H_FRAME) & (phase == PH_WAIT)
		& (cnt == {8'h00, `WAIT_GAP - 8'h01});
	assign fstep      = (bit_end & (bits == 5'h01)) | gap_end;
	assign np         = next_phase(phase, info);

	// Frame and probe sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			hst    <= H_IDLE;
			phase  <= PH_CODE;
			info   <= decode_cmd(8'h00);
			cnt    <= 16'h0000;
			bits   <= 5'h00;
			sh     <= 16'h0000;
			sstage <= 2'h0;
			push_q <= 16'h0000;
		end else begin
			case (hst)
			H_IDLE: begin
				cnt <= 16'h0000;
				if (sync_req) begin
					hst    <= H_SYNC;
					sstage <= 2'h0;
				end else if (cmd_valid) begin
					hst   <= H_FRAME;
					phase <= PH_CODE;
					info  <= decode_cmd(cmd_code);
					sh    <= {cmd_code, 8'h00};
					bits  <= `CODE_BITS;
				end
			end
			H_FRAME: begin
				if (fstep) begin
					cnt   <= 16'h0000;
					phase <= np;
					bits  <= field_len(np, info);
					if (np == PH_ADDR)
						sh <= addr_q;
					else if (np == PH_WIN)
						sh <= (info.wlen == `WORD_BITS) ? wdata_q : {wdata_q[7:0], 8'h00};
					push_q <= (info.rlen == `BYTE_BITS) ? {8'h00, sh[7:0]} : sh;
					if (np == PH_CODE)
						hst <= (info.rlen != 5'h00) ? H_PUSH : H_IDLE;
				end else if (bit_end) begin
					cnt  <= 16'h0000;
					bits <= bits - 5'h01;
					if (phase != PH_OUT)
						sh <= {sh[14:0], 1'b0};
				end else begin
					cnt <= cnt + 16'h0001;
					if (phase == PH_OUT && cnt == {8'h00, `HOST_SAMPLE})
						sh <= {sh[14:0], s3};
				end
			end
			H_SYNC: begin
				cnt <= cnt + 16'h0001;
				if (sstage == 2'h0 && cnt == {8'h00, `SYNC_REQ_LOW}) begin
					sstage <= 2'h1;
					cnt    <= 16'h0000;
				end else if (sstage == 2'h1 && ~s2 && s3) begin
					sstage <= 2'h2;
					cnt    <= 16'h0000;
				end else if (sstage == 2'h1 && cnt == `SYNC_TIMEOUT) begin
					push_q <= 16'h0000; // No answer: report zero length
					hst    <= H_PUSH;
				end else if (sstage == 2'h2 && s2 && ~s3) begin
					push_q <= cnt; // Measured probe answer in clock cycles
					hst    <= H_PUSH;
				end
			end
			H_PUSH: begin
				if (push_ready)
					hst <= H_IDLE;
			end
			default: hst <= H_IDLE;
			endcase
		end
	end

	// Address and write data held for the frame
	always_ff @(posedge clk) begin
		if (srst) begin
			addr_q  <= 16'h0000;
			wdata_q <= 16'h0000;
		end else if (hst == H_IDLE && cmd_valid && !sync_req) begin
			addr_q  <= cmd_addr;
			wdata_q <= cmd_wdata;
		end
	end

	// Pin drive: every bit opens low, then one cycle of speed-up before release
	always_ff @(posedge clk) begin
		if (srst) begin
			link.host_oe  <= 1'b0;
			link.host_out <= 1'b1;
		end else if ((hst == H_FRAME && phase != PH_WAIT && cnt < {8'h00, low_len})
			|| (hst == H_SYNC && sstage == 2'h0 && cnt < {8'h00, `SYNC_REQ_LOW})) begin
			link.host_oe  <= 1'b1; // Host opens every bit
			link.host_out <= 1'b0;
		end else if ((hst == H_FRAME && phase != PH_WAIT && cnt == {8'h00, low_len})
			|| (hst == H_SYNC && sstage == 2'h0 && cnt == {8'h00, `SYNC_REQ_LOW})) begin
			link.host_oe  <= 1'b1; // Speed-up pulse
			link.host_out <= 1'b1;
		end else begin
			link.host_oe  <= 1'b0;
			link.host_out <= 1'b1;
		end
	end

	// Answers wait here so a slow consumer loses none
	dbg_rsp_buffer #(
		.WIDTH(16),
		.DEPTH(2)
	) u_rsp_buffer (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_q),
		.out_valid (rsp_valid),
		.out_ready (rsp_ready),
		.out_data  (rsp_data)
	);
endmodule
`default_nettype wire

// ### verification/dbg_link_sva.sv
// Checker on the pin drives of both debug link ends
`timescale 1ns/10ps
`default_nettype none
module dbg_link_sva (
	input wire logic clk,      // Debug clock
	input wire logic srst,     // Synchronous reset
	input wire logic host_out, // Host pin value
	input wire logic host_oe,  // Host drives
	input wire logic tgt_out,  // Target pin value
	input wire logic tgt_oe,   // Target drives
	input wire logic level     // Resolved pin
);
	logic       tl;
	logic       hl;
	logic [7:0] tlow;
	logic [7:0] hlow;
	logic [7:0] since;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	assign tl = tgt_oe & ~tgt_out;
	assign hl = host_oe & ~host_out;
	// Length of the running low drive of each end
	always_ff @(posedge clk) begin
		tlow <= (srst || !tl) ? 8'h00 : tlow + 8'h01;
		hlow <= (srst || !hl) ? 8'h00 : hlow + 8'h01;
	end
	// Cycles since the host last pulled low; saturates so probes do not wrap
	always_ff @(posedge clk) begin
		if (srst)
			since <= 8'hff;
		else if (hl)
			since <= 8'h00;
		else if (since != 8'hff)
			since <= since + 8'h01;
	end
	a_zero_low_time: assert property (!tl && tlow != 0 |-> tlow == 8'h0d || tlow == 8'h80)
		else $error("target low drive has wrong length");
	a_tgt_speedup: assert property (!tl && tlow != 0 |-> tgt_oe && tgt_out ##1 !tgt_oe)
		else $error("target speed-up pulse missing");
	a_tgt_pulse_brief: assert property (tgt_oe && tgt_out |-> $past(tl))
		else $error("target drives high without a low phase");
	a_host_low_time: assert property (!hl && hlow != 0
		|-> hlow == 8'h04 || hlow == 8'h0d || hlow == 8'h50)
		else $error("host low drive has wrong length");
	a_host_speedup: assert property ($fell(hl) |-> host_oe && host_out ##1 !host_oe)
		else $error("host speed-up pulse missing");
	a_host_pulse_brief: assert property (host_oe && host_out |-> $past(hl))
		else $error("host drives high without a low phase");
	a_target_late: assert property ($rose(tgt_oe) |-> since <= 8'h03 || since >= 8'h0c)
		else $error("target drive not tied to a host edge");
	a_bit_spacing: assert property ($rose(hl) |-> since >= 8'h08)
		else $error("host bit starts too close together");
	a_idle_level: assert property (!host_oe && !tgt_oe |-> level)
		else $error("released pin not high");
	c_zero: cover property (!tl && tlow == 8'h0d);
	c_probe: cover property (!tl && tlow == 8'h80);
	c_sync: cover property (!hl && hlow == 8'h50);
endmodule
`default_nettype wire

// ### verification/tb_single_wire_debug_link.sv
// Testbench joining host and target ends of the debug link
`timescale 1ns/10ps
`default_nettype none
`include "dbg_link_map.svh"
module tb_single_wire_debug_link;
	logic        clk, srst, cmd_valid, cmd_ready, sync_req, rsp_valid, rsp_ready;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_addr, cmd_wdata, rsp_data, mem_addr, mem_wdata, mem_rdata, bkpt_addr, v;
	logic        mem_req, mem_we, mem_word, mem_ack, halted, bkpt_en, drove;
	logic [15:0] mem [0:255];
	int          bad_count, cmp_count, n_acc, n0;
	dbg_link_if link();
	dbg_target i_dbg_target (.clk(clk), .srst(srst), .link(link), .mem_req(mem_req),
		.mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .halted(halted), .bkpt_en(bkpt_en),
		.bkpt_addr(bkpt_addr));
	dbg_host i_dbg_host (.clk(clk), .srst(srst), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.sync_req(sync_req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
	dbg_link_sva i_dbg_link_sva (.clk(clk), .srst(srst), .host_out(link.host_out),
		.host_oe(link.host_oe), .tgt_out(link.tgt_out), .tgt_oe(link.tgt_oe), .level(link.level));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Memory answers in the same cycle as a request; read data is scrambled when idle
	always @(posedge clk) begin
		#1;
		mem_ack = mem_req & ~mem_ack;
		if (mem_ack && mem_we)
			mem[mem_addr[7:0]] = mem_wdata;
		mem_rdata = mem_ack ? mem[mem_addr[7:0]] : ~mem_rdata;
		if (mem_ack)
			n_acc++;
	end
	// Notes any target drive of the pin
	always @(posedge clk) begin
		if (link.tgt_oe)
			drove <= 1'b1;
	end
	task stop_test();
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task step(inout int n);
		@(posedge clk);
		#1;
		n++;
		if (n > 4000) begin
			bad_count++;
			stop_test();
		end
	endtask
	task offer(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		cmd_code = c;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			step(n);
		step(n);
		cmd_valid = 1'b0;
	endtask
	task send(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		offer(c, a, d);
		while (cmd_ready !== 1'b1)
			step(n);
	endtask
	task get_rsp(output logic [15:0] r);
		int n;
		n = 0;
		while (rsp_valid !== 1'b1)
			step(n);
		r = rsp_data;
		rsp_ready = 1'b1;
		step(n);
		rsp_ready = 1'b0;
		step(n);
	endtask
	// Non-intrusive access while the program runs; halt-only read refused
	task t_running();
		send(`CMD_WRITE_CONTROL, 16'h0000, 16'h00bf);
		chk(bkpt_en, 1'b1);
		send(`CMD_READ_STATUS, 16'h0000, 16'h0000);
		get_rsp(v);
		chk(v, 16'h00bf);
		n0 = n_acc;
		send(`CMD_WRITE_BYTE, 16'h0012, 16'h005a);
		chk(n_acc, n0 + 1);
		chk(mem_we, 1'b1);
		chk(mem_wdata, 16'h005a);
		chk(mem[8'h12], 16'h005a);
		chk(mem_addr, 16'h0012);
		send(`CMD_READ_BYTE, 16'h0012, 16'h0000);
		get_rsp(v);
		chk(v, 16'h005a);
		n0 = n_acc;
		send(`CMD_READ_WORD, 16'h0012, 16'h0000);
		get_rsp(v);
		chk(v, 16'hffff);
		chk(n_acc, n0);
	endtask
	// Halted commands: breakpoint and word round trips, then resume
	task t_halted();
		send(`CMD_BACKGROUND, 16'h0000, 16'h0000);
		chk(halted, 1'b1);
		send(`CMD_READ_STATUS, 16'h0000, 16'h0000);
		get_rsp(v);
		chk(v, 16'h00ff);
		send(`CMD_WRITE_BKPT, 16'h0000, 16'h1234);
		chk(bkpt_addr, 16'h1234);
		send(`CMD_READ_BKPT, 16'h0000, 16'h0000);
		get_rsp(v);
		chk(v, 16'h1234);
		send(`CMD_WRITE_WORD, 16'h0040, 16'hbeef);
		chk(mem_word, 1'b1);
		send(`CMD_READ_WORD, 16'h0040, 16'h0000);
		get_rsp(v);
		chk(v, 16'hbeef);
		send(`CMD_GO, 16'h0000, 16'h0000);
		chk(halted, 1'b0);
	endtask
	// Unknown code leaves the pin alone; then the answer buffer fills and stalls the host
	task t_unknown_and_fill();
		int n;
		n = 0;
		drove = 1'b0;
		send(8'h55, 16'h0000, 16'h0000);
		chk(drove, 1'b0);
		chk(rsp_valid, 1'b0);
		repeat (2)
			send(`CMD_READ_STATUS, 16'h0000, 16'h0000);
		offer(`CMD_READ_STATUS, 16'h0000, 16'h0000);
		repeat (500)
			step(n);
		chk(cmd_ready, 1'b0);
		repeat (3) begin
			get_rsp(v);
			chk(v, 16'h00bf);
		end
	endtask
	// Timing probe answered with a 128-cycle pulse
	task t_probe();
		sync_req = 1'b1;
		@(posedge clk);
		#1;
		sync_req = 1'b0;
		get_rsp(v);
		chk(v >= 16'h007f && v <= 16'h0081, 1'b1);
	endtask
	initial begin
		{srst, cmd_valid, sync_req, rsp_ready, mem_ack} = 5'b10000;
		{cmd_code, cmd_addr, cmd_wdata, mem_rdata} = '0;
		{bad_count, cmp_count, n_acc, drove} = '0;
		repeat (4)
			@(posedge clk);
		#1;
		srst = 1'b0;
		chk(halted, 1'b0);
		chk(link.tgt_oe, 1'b0);
		t_running();
		t_halted();
		t_unknown_and_fill();
		t_probe();
		stop_test();
	end
endmodule
`default_nettype wire
